// ---- design/intreg_file.sv ----
// Integer register file, flag register, scratch and identification registers
`timescale 1ns/10ps
module intreg_file (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic user_state_bit,
  input wire logic [4:0] rd_addr_a,
  input wire logic [4:0] rd_addr_b,
  input wire logic gpr_wr_en,
  input wire logic [4:0] gpr_wr_addr,
  input wire logic [31:0] gpr_wr_data,
  input wire logic [2:0] alu_op,
  input wire logic ov_en,
  input wire logic carry_en,
  input wire logic ext_en,
  input wire logic [4:0] shamt,
  input wire logic spr_rd_en,
  input wire logic spr_wr_en,
  input wire logic [9:0] spr_num,
  input wire logic [31:0] spr_wr_data,
  output logic [31:0] rd_data_a,
  output logic [31:0] rd_data_b,
  output logic [31:0] alu_result,
  output logic [3:0] cond_field_zero,
  output logic [6:0] string_byte_count,
  output logic [31:0] spr_rd_data,
  output logic priv_fault
);
  logic [31:0] greg_q [intreg_pkg::GREG_COUNT];
  logic [31:0] scratch_q [intreg_pkg::SCRATCH_COUNT];
  logic [31:0] user_scratch_q, cfg0_q, flags;
  logic [31:0] res_d;
  logic [3:0] cond_d;
  logic flag_wr, sup_ok, known, priv_only, fault_d;
  logic [31:0] rd_d;

  // Supervisor-only numbers, read or write
  function automatic logic is_priv(input logic [9:0] n);
    is_priv = (n[9:3] == intreg_pkg::SPR_SCR_RW_BASE[9:3])
      || n == intreg_pkg::SPR_VERSION || n == intreg_pkg::SPR_INSTANCE
      || n == intreg_pkg::SPR_CFG0;
  endfunction

  assign sup_ok = !user_state_bit;
  assign priv_only = is_priv(spr_num);
  assign flag_wr = spr_wr_en && spr_num == intreg_pkg::SPR_FLAGS;

  flag_unit u_flags (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .op(alu_op),
    .ov_en(ov_en),
    .carry_en(carry_en),
    .ext_en(ext_en),
    .opa(rd_data_a),
    .opb(rd_data_b),
    .shamt(shamt),
    .wr_en(flag_wr),
    .wr_data(spr_wr_data),
    .result_d(res_d),
    .cond_d(cond_d),
    .flags_q(flags)
  );

  // General registers, no privilege
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int i = 0; i < intreg_pkg::GREG_COUNT; i++) begin
        greg_q[i] <= intreg_pkg::RESET_WORD;
      end
    end else if (gpr_wr_en) begin
      greg_q[gpr_wr_addr] <= gpr_wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_data_a <= 32'h0;
      rd_data_b <= 32'h0;
      alu_result <= 32'h0;
      cond_field_zero <= 4'h0;
      string_byte_count <= 7'h0;
    end else begin
      rd_data_a <= greg_q[rd_addr_a];
      rd_data_b <= greg_q[rd_addr_b];
      alu_result <= res_d;
      if (alu_op == 3'(intreg_pkg::OP_FLAGS_TO_COND)) begin
        cond_field_zero <= cond_d;
      end
      string_byte_count <= flags[6:0];
    end
  end

  // Scratch and configuration writes, privileged ones gated
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      user_scratch_q <= intreg_pkg::RESET_WORD;
      cfg0_q <= intreg_pkg::RESET_WORD;
      for (int i = 0; i < intreg_pkg::SCRATCH_COUNT; i++) begin
        scratch_q[i] <= intreg_pkg::RESET_WORD;
      end
    end else if (spr_wr_en) begin
      if (spr_num == intreg_pkg::SPR_USER_SCRATCH) begin
        user_scratch_q <= spr_wr_data;
      end
      if (sup_ok && spr_num[9:3] == intreg_pkg::SPR_SCR_RW_BASE[9:3]) begin
        scratch_q[spr_num[2:0]] <= spr_wr_data;
      end
      if (sup_ok && spr_num == intreg_pkg::SPR_CFG0) begin
        cfg0_q <= spr_wr_data;
      end
    end
  end

  always_comb begin
    rd_d = 32'h0;
    known = 1'b1;
    if (spr_num == intreg_pkg::SPR_FLAGS) begin
      rd_d = flags;
    end else if (spr_num == intreg_pkg::SPR_USER_SCRATCH) begin
      rd_d = user_scratch_q;
    end else if (spr_num[9:2] == intreg_pkg::SPR_SCR_RO_BASE[9:2]) begin
      rd_d = scratch_q[{1'b1, spr_num[1:0]}];
    end else if (spr_num[9:3] == intreg_pkg::SPR_SCR_RW_BASE[9:3]) begin
      rd_d = scratch_q[spr_num[2:0]];
    end else if (spr_num == intreg_pkg::SPR_VERSION) begin
      rd_d = {intreg_pkg::OWNER_ID, intreg_pkg::VERSION_NUM};
    end else if (spr_num == intreg_pkg::SPR_INSTANCE) begin
      rd_d = {28'h0, intreg_pkg::INSTANCE_NUM};
    end else if (spr_num == intreg_pkg::SPR_CFG0) begin
      rd_d = cfg0_q;
    end else begin
      known = 1'b0;
    end
  end

  assign fault_d = (spr_rd_en || spr_wr_en) && user_state_bit && priv_only;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      spr_rd_data <= 32'h0;
      priv_fault <= 1'b0;
    end else begin
      priv_fault <= fault_d;
      if (spr_rd_en && !fault_d && known) begin
        spr_rd_data <= rd_d;
      end
    end
  end

  // Refused user access: fault pulse, read data left alone
  sequence user_priv_req;
    (spr_rd_en || spr_wr_en) && user_state_bit && priv_only;
  endsequence
  sequence refused_answer;
    priv_fault && $stable(spr_rd_data);
  endsequence

  fault_blocks_a: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    spr_wr_en && user_state_bit && spr_num == intreg_pkg::SPR_CFG0
    |=> priv_fault && $stable(cfg0_q)) else $error("user wrote cfg0");
  user_scr_a: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    spr_wr_en && spr_num == intreg_pkg::SPR_USER_SCRATCH
    |=> !priv_fault && user_scratch_q == $past(spr_wr_data))
    else $error("user scratch write lost");
  priv_refuse_a: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    user_priv_req |=> refused_answer) else $error("privileged access taken");
endmodule

// ---- design/intreg_pkg.sv ----
// Constants for the integer, flag, scratch and identification registers
package intreg_pkg;
  // Bit positions count from the least significant bit
  localparam int unsigned FLAG_SUMOV_BIT = 31;
  localparam int unsigned FLAG_RANGE_BIT = 30;
  localparam int unsigned FLAG_COUT_BIT = 29;
  localparam int unsigned FLAG_CNT_LSB = 0;
  localparam int unsigned CNT_W = 7;
  localparam int unsigned GREG_COUNT = 32;
  localparam int unsigned SCRATCH_COUNT = 8;
  // Special-register numbers
  localparam logic [9:0] SPR_FLAGS = 10'h001;
  localparam logic [9:0] SPR_USER_SCRATCH = 10'h100;
  localparam logic [9:0] SPR_SCR_RW_BASE = 10'h110;
  localparam logic [9:0] SPR_SCR_RO_BASE = 10'h104;
  localparam logic [9:0] SPR_VERSION = 10'h11f;
  localparam logic [9:0] SPR_INSTANCE = 10'h11e;
  localparam logic [9:0] SPR_CFG0 = 10'h3b3;
  localparam logic [11:0] OWNER_ID = 12'h5a5;   // Arbitrary value
  localparam logic [19:0] VERSION_NUM = 20'h00001; // Arbitrary value
  localparam logic [3:0] INSTANCE_NUM = 4'h0;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  typedef enum logic [2:0] {
    OP_NONE, OP_ADD, OP_SUB, OP_SRA, OP_MULACC_U, OP_ZLOC, OP_FLAGS_TO_COND
  } alu_op_e;
endpackage

// ---- design/flag_unit.sv ----
// Arithmetic flag register with overflow, carry and byte count updates
`timescale 1ns/10ps
module flag_unit (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [2:0] op,
  input wire logic ov_en,
  input wire logic carry_en,
  input wire logic ext_en,
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  input wire logic [4:0] shamt,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  output logic [31:0] result_d,
  output logic [3:0] cond_d,
  output logic [31:0] flags_q
);
  logic sumov_q, range_q, cout_q;
  logic [6:0] cnt_q;
  logic [32:0] sum;
  logic [32:0] wide;
  logic range_d, cout_d, lost;
  logic [31:0] mask;
  logic [6:0] zcnt;
  intreg_pkg::alu_op_e opc;

  assign opc = intreg_pkg::alu_op_e'(op);

  always_comb begin
    sum = 33'h0;
    wide = 33'h0;
    range_d = range_q;
    cout_d = cout_q;
    result_d = 32'h0;
    cond_d = 4'h0;
    mask = ~(32'hffffffff << shamt);
    lost = |(opa & mask);
    zcnt = 7'h4;
    unique case (opc)
      intreg_pkg::OP_ADD, intreg_pkg::OP_SUB: begin
        // Extended forms consume the stored carry
        wide = {1'b0, (opc == intreg_pkg::OP_SUB) ? ~opa : opa};
        sum = wide + {1'b0, opb} + {32'h0,
              ext_en ? cout_q : (opc == intreg_pkg::OP_SUB)};
        result_d = sum[31:0];
        if (carry_en) begin
          cout_d = sum[32];
        end
        if (ov_en) begin
          range_d = (wide[31] == opb[31]) && (sum[31] != opb[31]);
        end
      end
      intreg_pkg::OP_SRA: begin
        result_d = $signed(opa) >>> shamt;
        cout_d = opa[31] && lost;
      end
      intreg_pkg::OP_MULACC_U: begin
        sum = {1'b0, opa} + {1'b0, opb};
        result_d = sum[31:0];
        if (ov_en) begin
          range_d = sum[32];
        end
      end
      intreg_pkg::OP_ZLOC: begin
        // Later hits are more significant bytes, so the first zero wins
        for (int i = 0; i < 4; i++) begin
          if (opa[i*8 +: 8] == 8'h00) begin
            zcnt = 7'(4 - i);
          end
        end
        result_d = {25'h0, zcnt};
      end
      intreg_pkg::OP_FLAGS_TO_COND: begin
        cond_d = {sumov_q, range_q, cout_q, 1'b0};
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sumov_q <= 1'b0;
      range_q <= 1'b0;
      cout_q <= 1'b0;
      cnt_q <= 7'h0;
    end else if (wr_en) begin
      sumov_q <= wr_data[intreg_pkg::FLAG_SUMOV_BIT];
      range_q <= wr_data[intreg_pkg::FLAG_RANGE_BIT];
      cout_q <= wr_data[intreg_pkg::FLAG_COUT_BIT];
      cnt_q <= wr_data[intreg_pkg::FLAG_CNT_LSB +: intreg_pkg::CNT_W];
    end else if (opc == intreg_pkg::OP_FLAGS_TO_COND) begin
      sumov_q <= 1'b0;
      range_q <= 1'b0;
      cout_q <= 1'b0;
    end else begin
      range_q <= range_d;
      cout_q <= cout_d;
      if (range_d && ov_en) begin
        sumov_q <= 1'b1;
      end
      if (opc == intreg_pkg::OP_ZLOC) begin
        cnt_q <= zcnt;
      end
    end
  end

  // Reserved bits 7:28 are constant zero
  assign flags_q = {sumov_q, range_q, cout_q, 22'h0, cnt_q};

  // Flags move without a direct write, then all three flags cleared
  sequence flags_move;
    opc == intreg_pkg::OP_FLAGS_TO_COND && !wr_en;
  endsequence
  sequence flags_cleared;
    flags_q[31:29] == 3'h0 && $stable(cnt_q);
  endsequence

  sumov_sticky_a: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    sumov_q && !wr_en && opc != intreg_pkg::OP_FLAGS_TO_COND
    |=> sumov_q) else $error("summary overflow dropped");
  ov_sets_sum_a: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    !wr_en && ov_en && range_d && opc != intreg_pkg::OP_FLAGS_TO_COND
    |=> sumov_q && range_q) else $error("overflow missed summary");
  move_clears_a: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    flags_move |=> flags_cleared) else $error("flags move left flags set");
endmodule

// ---- dv/spr_master.sv ----
// Software side model issuing special-register moves
`timescale 1ns/10ps
module spr_master (
  input wire logic clk_sys,
  input wire logic [31:0] spr_rd_data,
  input wire logic priv_fault,
  output logic spr_rd_en,
  output logic spr_wr_en,
  output logic [9:0] spr_num,
  output logic [31:0] spr_wr_data
);
  initial begin
    spr_rd_en = 1'b0;
    spr_wr_en = 1'b0;
    spr_num = 10'h000;
    spr_wr_data = 32'h00000000;
  end
  // Answer is taken just after the edge that samples the request
  task automatic xfer(input logic wr, input logic [9:0] num,
      input logic [31:0] wd, output logic [31:0] rd, output logic flt);
    @(posedge clk_sys);
    spr_rd_en <= !wr;
    spr_wr_en <= wr;
    spr_num <= num;
    spr_wr_data <= wd;
    @(posedge clk_sys);
    spr_rd_en <= 1'b0;
    spr_wr_en <= 1'b0;
    spr_wr_data <= ~wd;
    #1;
    flt = priv_fault;
    rd = spr_rd_data;
    @(posedge clk_sys);
  endtask
endmodule

// ---- dv/intreg_file_tb.sv ----
// Self-checking bench for the integer and control register block
`timescale 1ns/10ps
module intreg_file_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic user_state_bit = 1'b0;
  logic [4:0] rd_addr_a = 5'h00, rd_addr_b = 5'h00, gpr_wr_addr = 5'h00;
  logic gpr_wr_en = 1'b0, ov_en = 1'b0, carry_en = 1'b0, ext_en = 1'b0;
  logic [31:0] gpr_wr_data = 32'h00000000;
  logic [2:0] alu_op = 3'h0;
  logic [4:0] shamt = 5'h00;
  logic spr_rd_en, spr_wr_en, priv_fault;
  logic [9:0] spr_num;
  logic [31:0] spr_wr_data, spr_rd_data, rd_data_a, rd_data_b, alu_result;
  logic [3:0] cond_field_zero;
  logic [6:0] string_byte_count;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  intreg_file i_dut (.clk_sys, .reset_n, .user_state_bit, .rd_addr_a,
    .rd_addr_b, .gpr_wr_en, .gpr_wr_addr, .gpr_wr_data, .alu_op, .ov_en,
    .carry_en, .ext_en, .shamt, .spr_rd_en, .spr_wr_en, .spr_num,
    .spr_wr_data, .rd_data_a, .rd_data_b, .alu_result, .cond_field_zero,
    .string_byte_count, .spr_rd_data, .priv_fault);
  spr_master i_sw (.clk_sys, .spr_rd_data, .priv_fault, .spr_rd_en,
    .spr_wr_en, .spr_num, .spr_wr_data);
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic summarize;
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic mv(input logic wr, input logic [9:0] n,
      input logic [31:0] d, input logic [31:0] e, input logic ef);
    logic [31:0] r;
    logic f;
    i_sw.xfer(wr, n, d, r, f);
    if (!wr) chk(r, e);
    chk({31'h0, f}, {31'h0, ef});
  endtask
  task automatic fl(input logic [31:0] e);
    mv(1'b0, intreg_pkg::SPR_FLAGS, 32'h0, e, 1'b0);
  endtask
  task automatic mode(input logic u);
    @(posedge clk_sys);
    user_state_bit <= u;
  endtask
  task automatic gw(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    gpr_wr_en <= 1'b1;
    gpr_wr_addr <= a;
    gpr_wr_data <= d;
    @(posedge clk_sys);
    gpr_wr_en <= 1'b0;
  endtask
  // Operands go through registers 1 and 2, op is pulsed one cycle;
  // returns just after the edge that registers the one-cycle result
  task automatic alu(input logic [2:0] op, input logic [2:0] en,
      input logic [31:0] a, input logic [31:0] b, input logic [4:0] sh);
    gw(5'h01, a);
    gw(5'h02, b);
    rd_addr_a <= 5'h01;
    rd_addr_b <= 5'h02;
    repeat (2) @(posedge clk_sys);
    alu_op <= op;
    {ov_en, carry_en, ext_en} <= en;
    shamt <= sh;
    @(posedge clk_sys);
    alu_op <= 3'h0;
    {ov_en, carry_en, ext_en} <= 3'h0;
    #1;
  endtask
  task automatic t_gpr;
    mode(1'b1);
    for (int i = 0; i < 32; i++) gw(5'(i), {27'h2d2d2d2, 5'(i)});
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_sys);
      rd_addr_a <= 5'(i);
      rd_addr_b <= 5'(31 - i);
      repeat (2) @(posedge clk_sys);
      #1 chk(rd_data_a, {27'h2d2d2d2, 5'(i)});
      chk(rd_data_b, {27'h2d2d2d2, 5'(31 - i)});
    end
  endtask
  task automatic t_flags;
    mv(1'b1, intreg_pkg::SPR_FLAGS, 32'hffffffff, 0, 1'b0);
    fl(32'he000007f);
    mv(1'b1, intreg_pkg::SPR_FLAGS, 32'h40000000, 0, 1'b0);
    fl(32'h40000000);
    mv(1'b1, intreg_pkg::SPR_FLAGS, 32'h0, 0, 1'b0);
    fl(32'h0);
  endtask
  task automatic t_arith;
    alu(intreg_pkg::OP_ADD, 3'b100, 32'h7fffffff, 32'h1, 5'h0);
    chk(alu_result, 32'h80000000);
    fl(32'hc0000000);
    alu(intreg_pkg::OP_ADD, 3'b100, 32'h1, 32'h1, 5'h0);
    fl(32'h80000000);
    alu(intreg_pkg::OP_FLAGS_TO_COND, 3'b000, 32'h0, 32'h0, 5'h0);
    chk({28'h0, cond_field_zero}, 32'h8);
    fl(32'h0);
    alu(intreg_pkg::OP_ADD, 3'b100, 32'h80000000, 32'hffffffff, 5'h0);
    fl(32'hc0000000);
    mv(1'b1, intreg_pkg::SPR_FLAGS, 32'h0, 0, 1'b0);
    alu(intreg_pkg::OP_ADD, 3'b010, 32'hffffffff, 32'h1, 5'h0);
    fl(32'h20000000);
    alu(intreg_pkg::OP_ADD, 3'b011, 32'h0, 32'h0, 5'h0);
    chk(alu_result, 32'h1);
    fl(32'h0);
    alu(intreg_pkg::OP_SUB, 3'b010, 32'h0, 32'h5, 5'h0);
    chk(alu_result, 32'h5);
    fl(32'h20000000);
    alu(intreg_pkg::OP_SRA, 3'b010, 32'h80000001, 32'h0, 5'h1);
    chk(alu_result, 32'hc0000000);
    fl(32'h20000000);
    alu(intreg_pkg::OP_SRA, 3'b010, 32'h80000000, 32'h0, 5'h1);
    fl(32'h0);
    alu(intreg_pkg::OP_SRA, 3'b010, 32'h3, 32'h0, 5'h1);
    fl(32'h0);
    alu(intreg_pkg::OP_MULACC_U, 3'b100, 32'hffffffff, 32'h1, 5'h0);
    fl(32'hc0000000);
    mv(1'b1, intreg_pkg::SPR_FLAGS, 32'h0, 0, 1'b0);
    alu(intreg_pkg::OP_MULACC_U, 3'b100, 32'hfffffffe, 32'h1, 5'h0);
    fl(32'h0);
    alu(intreg_pkg::OP_ZLOC, 3'b000, 32'h11000022, 32'h11111111,
      5'h0);
    // The count output follows the flag word one edge later
    @(posedge clk_sys);
    #1;
    chk({25'h0, string_byte_count}, 32'h2);
    fl(32'h2);
    alu(intreg_pkg::OP_ZLOC, 3'b000, 32'h11111111, 32'h11111111,
      5'h0);
    fl(32'h4);
  endtask
  task automatic t_priv;
    mv(1'b1, intreg_pkg::SPR_USER_SCRATCH, 32'h1234abcd, 0, 1'b0);
    mv(1'b0, intreg_pkg::SPR_USER_SCRATCH, 0, 32'h1234abcd, 1'b0);
    mode(1'b0);
    for (int i = 0; i < 8; i++) begin
      mv(1'b1, intreg_pkg::SPR_SCR_RW_BASE + 10'(i), 32'h5c000000 + i,
        0, 1'b0);
      mv(1'b0, intreg_pkg::SPR_SCR_RW_BASE + 10'(i), 0, 32'h5c000000 + i,
        1'b0);
    end
    mv(1'b1, intreg_pkg::SPR_CFG0, 32'h000000f0, 0, 1'b0);
    mv(1'b0, intreg_pkg::SPR_CFG0, 0, 32'h000000f0, 1'b0);
    mv(1'b0, intreg_pkg::SPR_VERSION, 0,
      {intreg_pkg::OWNER_ID, intreg_pkg::VERSION_NUM}, 1'b0);
    mv(1'b0, intreg_pkg::SPR_INSTANCE, 0,
      {28'h0, intreg_pkg::INSTANCE_NUM}, 1'b0);
    mode(1'b1);
    for (int i = 4; i < 8; i++) begin
      mv(1'b0, intreg_pkg::SPR_SCR_RO_BASE + 10'(i - 4), 0,
        32'h5c000000 + i, 1'b0);
    end
    mv(1'b1, intreg_pkg::SPR_SCR_RW_BASE + 10'h5, 32'h0, 0, 1'b1);
    mv(1'b0, intreg_pkg::SPR_SCR_RO_BASE + 10'h1, 0, 32'h5c000005,
      1'b0);
    mv(1'b0, intreg_pkg::SPR_SCR_RW_BASE, 0, 32'h5c000005, 1'b1);
    mv(1'b0, intreg_pkg::SPR_VERSION, 0, 32'h5c000005, 1'b1);
    mv(1'b0, intreg_pkg::SPR_INSTANCE, 0, 32'h5c000005, 1'b1);
    mv(1'b1, intreg_pkg::SPR_CFG0, 32'h0, 0, 1'b1);
    mode(1'b0);
    mv(1'b0, intreg_pkg::SPR_CFG0, 0, 32'h000000f0, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_gpr();
    t_flags();
    t_arith();
    t_priv();
    summarize();
  end
endmodule
